// *** dawc_pkg.sv ***
// constants and types for the dual attenuator wiper control
package dawc_pkg;

    // ****************************************
    // clock and timing
    // ****************************************
    localparam int unsigned CLK_HZ       = 40_000_000;
    localparam int unsigned ZC_WINDOW_MS = 50;
    // longest wait rounds down to whole cycles
    localparam int unsigned ZC_WINDOW_CYC =
        32'(longint'(ZC_WINDOW_MS) * longint'(CLK_HZ) / 64'd1000);
    localparam int unsigned TMR_W = 21;

    // ****************************************
    // widths and field positions
    // ****************************************
    localparam int unsigned POS_W       = 6;
    localparam int unsigned ATT_W       = 7;
    localparam int unsigned CFG_W       = 3;
    localparam int unsigned CFG_TAP_BIT = 0;
    localparam int unsigned CFG_ZC_BIT  = 1;
    localparam int unsigned CFG_VOL_BIT = 2;

    // ****************************************
    // command selector codes
    // ****************************************
    localparam logic [1:0] SEL_CH0  = 2'h0;
    localparam logic [1:0] SEL_CH1  = 2'h1;
    localparam logic [1:0] SEL_CFG  = 2'h2;
    localparam logic [1:0] SEL_RSVD = 2'h3;

    // ****************************************
    // values after reset
    // ****************************************
    // volatile on, zero crossing on, first tap option
    localparam logic [CFG_W-1:0] CFG_RESET   = 3'h6;
    localparam logic [POS_W-1:0] WIPER_RESET = 6'h3F;

    // ****************************************
    // tap option tables
    // ****************************************
    localparam logic [ATT_W-1:0] MUTE_ATT     = 7'h50;
    localparam logic [POS_W-1:0] OPT1_MUTE    = 6'h3F;
    localparam logic [POS_W-1:0] OPT2_MUTE    = 6'h21;
    localparam logic [POS_W-1:0] OPT2_SEG1_END = 6'h0C;
    localparam logic [POS_W-1:0] OPT2_SEG2_END = 6'h18;
    localparam logic [ATT_W-1:0] OPT2_SEG2_BASE = 7'h0C;
    localparam logic [ATT_W-1:0] OPT2_SEG3_BASE = 7'h24;

    // ****************************************
    // types
    // ****************************************
    typedef struct packed {
        logic [1:0]       sel;
        logic [POS_W-1:0] arg;
    } dawc_cmd_t;

    typedef enum logic {
        CH_IDLE = 1'b0,
        CH_WAIT = 1'b1
    } dawc_ch_st_t;

    typedef struct packed {
        logic [1:0]                  eq_meta;
        logic [1:0]                  eq_sync;
        logic [CFG_W-1:0]            cfg;
        dawc_ch_st_t [1:0]           ch_st;
        logic [1:0][POS_W-1:0]       wiper;
        logic [1:0][POS_W-1:0]       target;
        logic [1:0][TMR_W-1:0]       timer;
        logic [1:0][ATT_W-1:0]       atten;
        logic [1:0]                  mute;
        logic                        nv_req;
        logic                        stop_seen;
        logic                        nv_start;
    } dawc_state_t;

endpackage

// *** dawc_core.sv ***
// command decode, zero-crossing gated wiper update and attenuation mapping
`timescale 1ns/1ps

module dawc_core
#(
    parameter int unsigned WIN_CYC = dawc_pkg::ZC_WINDOW_CYC
)
(
    input  wire logic                                  ref_clk,
    input  wire logic                                  reset,
    input  wire logic                                  cmd_valid,
    input  wire dawc_pkg::dawc_cmd_t                   cmd,
    input  wire logic                                  bus_stop,
    input  wire logic [1:0]                            term_equal,
    output logic      [1:0][dawc_pkg::POS_W-1:0]       wiper_pos,
    output logic      [1:0][dawc_pkg::ATT_W-1:0]       atten_db,
    output logic      [1:0]                            mute,
    output logic      [1:0]                            update_pending,
    output logic                                       zc_enable,
    output logic                                       tap_option,
    output logic                                       volatile_mode,
    output logic                                       nv_write_start
);

    // ****************************************
    // attenuation lookup
    // ****************************************
    function automatic logic [dawc_pkg::ATT_W-1:0] atten_of
    (
        input logic [dawc_pkg::POS_W-1:0] pos,
        input logic                       opt
    );
        logic [dawc_pkg::ATT_W-1:0] p;
        p = {1'b0, pos};
        atten_of = p;
        if (!opt)
        begin
            if (pos == dawc_pkg::OPT1_MUTE)
            begin
                atten_of = dawc_pkg::MUTE_ATT;
            end
        end
        else
        begin
            if (pos >= dawc_pkg::OPT2_MUTE)
            begin
                atten_of = dawc_pkg::MUTE_ATT;
            end
            else if (pos > dawc_pkg::OPT2_SEG2_END)
            begin
                atten_of = 7'(dawc_pkg::OPT2_SEG3_BASE
                    + 7'h03 * (p - {1'b0, dawc_pkg::OPT2_SEG2_END}));
            end
            else if (pos > dawc_pkg::OPT2_SEG1_END)
            begin
                atten_of = 7'(dawc_pkg::OPT2_SEG2_BASE
                    + 7'h02 * (p - {1'b0, dawc_pkg::OPT2_SEG1_END}));
            end
        end
    endfunction

    // ****************************************
    // state
    // ****************************************
    dawc_pkg::dawc_state_t st;
    dawc_pkg::dawc_state_t next_st;

    logic [dawc_pkg::TMR_W-1:0] win_load;
    assign win_load = dawc_pkg::TMR_W'(WIN_CYC - 32'h1);

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        logic       zc_on;
        logic       opt;
        logic       hit;
        logic       any_wait;
        logic [1:0] chsel;
        zc_on    = st.cfg[dawc_pkg::CFG_ZC_BIT];
        opt      = 1'b0;
        hit      = 1'b0;
        any_wait = 1'b0;
        chsel    = 2'h0;
        next_st  = st;

        // two-flop sync of the terminal comparators
        next_st.eq_meta  = term_equal;
        next_st.eq_sync  = st.eq_meta;
        next_st.nv_start = 1'b0;

        if (cmd_valid && cmd.sel == dawc_pkg::SEL_CFG)
        begin
            next_st.cfg = cmd.arg[dawc_pkg::CFG_W-1:0];
        end

        opt = next_st.cfg[dawc_pkg::CFG_TAP_BIT];

        for (int ch = 0; ch < 2; ch++)
        begin
            chsel = (ch == 0) ? dawc_pkg::SEL_CH0 : dawc_pkg::SEL_CH1;
            hit = cmd_valid && (cmd.sel == chsel);
            if (hit)
            begin
                if (!zc_on)
                begin
                    next_st.wiper[ch] = cmd.arg;
                    next_st.ch_st[ch] = dawc_pkg::CH_IDLE;
                end
                else
                begin
                    next_st.target[ch] = cmd.arg;
                    next_st.timer[ch]  = win_load;
                    next_st.ch_st[ch]  = dawc_pkg::CH_WAIT;
                end
            end
            else
            begin
                case (st.ch_st[ch])
                    dawc_pkg::CH_WAIT:
                    begin
                        // move on crossing or window end
                        if (!zc_on || st.eq_sync[ch] || st.timer[ch] == '0)
                        begin
                            next_st.wiper[ch] = st.target[ch];
                            next_st.ch_st[ch] = dawc_pkg::CH_IDLE;
                        end
                        else
                        begin
                            next_st.timer[ch] = st.timer[ch] - 1'b1;
                        end
                    end
                    default:
                    begin
                        next_st.ch_st[ch] = dawc_pkg::CH_IDLE;
                    end
                endcase
            end
            if (next_st.ch_st[ch] == dawc_pkg::CH_WAIT)
            begin
                any_wait = 1'b1;
            end
            next_st.atten[ch] = atten_of(next_st.wiper[ch], opt);
            next_st.mute[ch]  = (next_st.atten[ch] == dawc_pkg::MUTE_ATT);
        end

        // storage write start after STOP and any wait
        if (st.nv_req && st.stop_seen && !(zc_on && any_wait))
        begin
            next_st.nv_start  = !st.cfg[dawc_pkg::CFG_VOL_BIT];
            next_st.nv_req    = 1'b0;
            next_st.stop_seen = 1'b0;
        end
        if (bus_stop && st.nv_req)
        begin
            next_st.stop_seen = 1'b1;
        end
        if (cmd_valid && cmd.sel != dawc_pkg::SEL_RSVD)
        begin
            next_st.nv_req    = 1'b1;
            next_st.stop_seen = 1'b0;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            st        <= '0;
            st.cfg    <= dawc_pkg::CFG_RESET;
            st.wiper  <= {2{dawc_pkg::WIPER_RESET}};
            st.target <= {2{dawc_pkg::WIPER_RESET}};
            st.atten  <= {2{dawc_pkg::MUTE_ATT}};
            st.mute   <= 2'h3;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ****************************************
    // outputs, all straight from state flops
    // ****************************************
    assign wiper_pos         = st.wiper;
    assign atten_db          = st.atten;
    assign mute              = st.mute;
    assign update_pending[0] = (st.ch_st[0] == dawc_pkg::CH_WAIT);
    assign update_pending[1] = (st.ch_st[1] == dawc_pkg::CH_WAIT);
    assign zc_enable         = st.cfg[dawc_pkg::CFG_ZC_BIT];
    assign tap_option        = st.cfg[dawc_pkg::CFG_TAP_BIT];
    assign volatile_mode     = st.cfg[dawc_pkg::CFG_VOL_BIT];
    assign nv_write_start    = st.nv_start;

endmodule

// *** dawc_core_sva.sv ***
// port assertions for the wiper control core
`timescale 1ns/1ps
module dawc_core_sva
#(
    parameter int unsigned WIN_CYC = 20
)
(
    input wire logic             ref_clk,
    input wire logic             reset,
    input wire logic             cmd_valid,
    input wire dawc_pkg::dawc_cmd_t cmd,
    input wire logic [1:0]       term_equal,
    input wire logic [1:0][5:0]  wiper_pos,
    input wire logic [1:0][6:0]  atten_db,
    input wire logic [1:0]       mute,
    input wire logic [1:0]       update_pending,
    input wire logic             zc_enable,
    input wire logic             tap_option,
    input wire logic             nv_write_start
);
    logic [31:0] wait_cnt;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    // cycles a channel 1 update has been waiting
    always_ff @(posedge ref_clk)
    begin
        if (reset || (cmd_valid && cmd.sel == 2'h1))
            wait_cnt <= 32'h0;
        else if (update_pending[1])
            wait_cnt <= wait_cnt + 32'h1;
    end
    a_ch0_direct: assert property (cmd_valid && cmd.sel == 2'h0 && !zc_enable
        |=> wiper_pos[0] == $past(cmd.arg)) else $error("ch0 wiper not taken");
    a_ch1_direct: assert property (cmd_valid && cmd.sel == 2'h1 && !zc_enable
        |=> wiper_pos[1] == $past(cmd.arg)) else $error("ch1 wiper not taken");
    a_cfg_write: assert property (cmd_valid && cmd.sel == 2'h2
        |=> {zc_enable, tap_option} == $past(cmd.arg[1:0])) else $error("config not taken");
    a_rsvd_none: assert property (cmd_valid && cmd.sel == 2'h3 && update_pending == 2'h0
        |=> $stable(wiper_pos) && $stable({zc_enable, tap_option})) else $error("reserved acted");
    a_pend_rise: assert property (cmd_valid && cmd.sel == 2'h0 && zc_enable
        |=> update_pending[0] && $stable(wiper_pos[0])) else $error("ch0 moved ungated");
    a_zc_move: assert property (update_pending[0] && term_equal[0] && !cmd_valid
        |-> ##[1:3] !update_pending[0]) else $error("ch0 ignored crossing");
    a_win_bound: assert property (update_pending[1] |-> wait_cnt <= WIN_CYC)
        else $error("ch1 window overrun");
    a_opt1_map: assert property (!tap_option && !mute[0]
        |-> atten_db[0] == {1'b0, wiper_pos[0]}) else $error("option one map");
    a_mute_att: assert property (mute[0] == (atten_db[0] == 7'h50))
        else $error("mute flag vs attenuation");
    a_nv_pulse: assert property (nv_write_start |=> !nv_write_start)
        else $error("storage start not a pulse");
endmodule
bind dawc_core dawc_core_sva #(.WIN_CYC(WIN_CYC)) dawc_core_sva_inst (.ref_clk(ref_clk), .reset(reset),
    .cmd_valid(cmd_valid), .cmd(cmd), .term_equal(term_equal), .wiper_pos(wiper_pos), .atten_db(atten_db),
    .mute(mute), .update_pending(update_pending), .zc_enable(zc_enable), .tap_option(tap_option),
    .nv_write_start(nv_write_start));

// *** dawc_master.sv ***
// bus master model handing command bytes to the core
`timescale 1ns/1ps
module dawc_master
(
    input  wire logic        ref_clk,
    output dawc_pkg::dawc_cmd_t cmd,
    output logic             cmd_valid,
    output logic             bus_stop
);
    initial
    begin
        cmd = 8'h00;
        cmd_valid = 1'b0;
        bus_stop = 1'b0;
    end
    // selector as asked
    // one write transfer: acknowledged byte, then a stop
    task automatic send(input logic [1:0] sel, input logic [5:0] arg);
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd <= {sel, arg};
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        cmd <= ~{sel, arg}; // stale byte is not left on the lines
        bus_stop <= 1'b1;
        @(posedge ref_clk);
        bus_stop <= 1'b0;
    endtask
endmodule

// *** dawc_core_tb.sv ***
// self-checking bench for the wiper control core
`timescale 1ns/1ps
module dawc_core_tb;
    localparam int WIN = 20;
    logic ref_clk, reset, cmd_valid, bus_stop, zc_clk, zc_on, zc_enable, tap_option, vol, nv;
    dawc_pkg::dawc_cmd_t cmd;
    logic [1:0][5:0] wiper_pos;
    logic [1:0][6:0] atten_db;
    logic [1:0] mute, update_pending;
    int n_errors, n_checks;
    int n_nv = 0;
    // clocks: core at 40 MHz, crossing stimulus at 200 ns
    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    initial
    begin
        zc_clk = 1'b0;
        #7;
        forever #100 zc_clk = ~zc_clk;
    end
    dawc_master m (.ref_clk(ref_clk), .cmd(cmd), .cmd_valid(cmd_valid), .bus_stop(bus_stop));
    dawc_core #(.WIN_CYC(WIN)) dawc_core_inst (.ref_clk(ref_clk), .reset(reset), .cmd_valid(cmd_valid),
        .cmd(cmd), .bus_stop(bus_stop), .term_equal({1'b0, zc_clk & zc_on}), .wiper_pos(wiper_pos),
        .atten_db(atten_db), .mute(mute), .update_pending(update_pending), .zc_enable(zc_enable),
        .tap_option(tap_option), .volatile_mode(vol), .nv_write_start(nv));
    // count storage start pulses
    always @(posedge ref_clk)
        if (nv === 1'b1)
            n_nv++;
    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    // bounded wait for a channel update to land
    task automatic wait_idle(input int ch, input int lim);
        for (int i = 0; i < lim && update_pending[ch] !== 1'b0; i++)
            @(posedge ref_clk) #1;
        if (update_pending[ch] !== 1'b0)
        begin
            n_errors++;
            $display("[FAIL] pending expected 0 seen 1");
            test_done();
        end
    endtask
    task automatic t_reset();
        chk("wiper0", 8'h3F, 8'(wiper_pos[0]));
        chk("tap", 8'h00, 8'(tap_option));
        chk("zc", 8'h01, 8'(zc_enable));
        chk("volatile", 8'h01, 8'(vol));
        chk("mute", 8'h03, 8'(mute));
    endtask
    task automatic t_direct();
        m.send(2'h2, 6'h38);
        m.send(2'h0, 6'h05);
        m.send(2'h1, 6'h3E);
        #1;
        chk("wiper0", 8'h05, 8'(wiper_pos[0]));
        chk("volatile", 8'h00, 8'(vol));
        chk("wiper1", 8'h3E, 8'(wiper_pos[1]));
        chk("atten1", 8'h3E, 8'(atten_db[1]));
        chk("nv starts", 8'h01, 8'(n_nv != 0));
    endtask
    task automatic t_opt2();
        logic [7:0] e;
        m.send(2'h2, 6'h01);
        for (int p = 0; p < 34; p++)
        begin
            e = (p == 33) ? 8'h50 : (p <= 12) ? 8'(p) : (p <= 24) ? 8'(2 * p - 12) : 8'(3 * p - 36);
            m.send(2'h0, 6'(p));
            #1;
            chk("atten0", e, 8'(atten_db[0]));
        end
        chk("atten1", 8'h50, 8'(atten_db[1]));
        chk("mute0", 8'h01, 8'(mute[0]));
    endtask
    task automatic t_rsvd();
        m.send(2'h3, 6'h00);
        #1;
        chk("tap", 8'h01, 8'(tap_option));
        chk("wiper0", 8'h21, 8'(wiper_pos[0]));
    endtask
    task automatic t_zc();
        m.send(2'h2, 6'h02);
        m.send(2'h0, 6'h07);
        #1;
        chk("held0", 8'h21, 8'(wiper_pos[0]));
        zc_on = 1'b1;
        wait_idle(0, 12);
        zc_on = 1'b0;
        chk("wiper0", 8'h07, 8'(wiper_pos[0]));
        m.send(2'h1, 6'h09);
        repeat (WIN - 4) @(posedge ref_clk);
        m.send(2'h1, 6'h0A);
        #1;
        chk("pending1", 8'h01, 8'(update_pending[1]));
        wait_idle(1, WIN + 4);
        chk("wiper1", 8'h0A, 8'(wiper_pos[1]));
    endtask
    // main sequence
    initial
    begin
        n_errors = 0;
        n_checks = 0;
        zc_on = 1'b0;
        reset = 1'b1;
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        #1;
        t_reset();
        t_direct();
        t_opt2();
        t_rsvd();
        t_zc();
        test_done();
    end
endmodule
